/* File: logic/rcr_pkg.sv */
package rcr_pkg;

  // ----------------------------------------------------------------
  // register offsets (byte addresses on the apb port)
  // ----------------------------------------------------------------
  localparam logic [7:0] RCR_OFF_CAUSE = 8'h00;
  localparam logic [7:0] RCR_OFF_IRQ_STS = 8'h04;
  localparam logic [7:0] RCR_OFF_IRQ_CLR = 8'h08;
  localparam logic [7:0] RCR_OFF_IRQ_EN = 8'h0C;
  localparam logic [7:0] RCR_OFF_SEG_LO = 8'h10;
  localparam logic [7:0] RCR_OFF_SEG_HI = 8'h14;

  // ----------------------------------------------------------------
  // reset cause flag positions
  // ----------------------------------------------------------------
  localparam int RCR_B_TRAP = 15;
  localparam int RCR_B_ILL = 14;
  localparam int RCR_B_CM = 9;
  localparam int RCR_B_PIN = 7;
  localparam int RCR_B_SWR = 6;
  localparam int RCR_B_WDT = 4;
  localparam int RCR_B_SLEEP = 3;
  localparam int RCR_B_IDLE = 2;
  localparam int RCR_B_BOR = 1;
  localparam int RCR_B_POR = 0;

  // implemented bits, power-on value, bits a brown-out leaves alone
  localparam logic [15:0] RCR_IMPL_MASK = 16'hC2DF;
  localparam logic [15:0] RCR_CAUSE_RST = 16'h0003;
  localparam logic [15:0] RCR_BOR_KEEP = 16'h0083;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int RCR_PC_W = 24;
  localparam int RCR_WREG_NUM = 16;
  localparam int RCR_SP_IDX = 15;

  // ----------------------------------------------------------------
  // kind of program counter reload
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    RCR_K_CALL,
    RCR_K_JUMP,
    RCR_K_CJUMP,
    RCR_K_RET,
    RCR_K_RETSUB,
    RCR_K_BRANCH,
    RCR_K_IVEC,
    RCR_K_TVEC
  } rcr_flow_t;

  // program flow change: call, jumps, returns, branches
  function automatic logic is_pfc(input rcr_flow_t k);
    is_pfc = (k == RCR_K_CALL) || (k == RCR_K_JUMP) ||
      (k == RCR_K_CJUMP) || (k == RCR_K_RET) ||
      (k == RCR_K_RETSUB) || (k == RCR_K_BRANCH);
  endfunction : is_pfc

  // vector flow change: interrupt or trap vector load
  function automatic logic is_vfc(input rcr_flow_t k);
    is_vfc = (k == RCR_K_IVEC) || (k == RCR_K_TVEC);
  endfunction : is_vfc

endpackage : rcr_pkg

/* File: logic/rcr_wreg_track.sv */
`timescale 1ns/100ps
module rcr_wreg_track #(
  parameter int NUM_WREG = rcr_pkg::RCR_WREG_NUM,
  parameter int SP_IDX = rcr_pkg::RCR_SP_IDX
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic wreg_clear,
  input wire logic wreg_wr,
  input wire logic [$clog2(NUM_WREG)-1:0] wreg_wr_idx,
  input wire logic wreg_ptr_use,
  input wire logic [$clog2(NUM_WREG)-1:0] wreg_ptr_idx,
  output logic uninit_fault
);

  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  if (NUM_WREG < 2 || SP_IDX >= NUM_WREG || SP_IDX < 0) begin : g_chk
    $error("rcr_wreg_track: bad register count or stack index");
  end

  logic [NUM_WREG-1:0] init_q;

  // written-since-reset marks; a reset beats a write in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      init_q <= '0;
    end else if (wreg_clear) begin
      init_q <= '0;
    end else if (wreg_wr) begin
      init_q[wreg_wr_idx] <= 1'b1;
    end
  end

  // pointer use of a never-written register; stack pointer is exempt
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      uninit_fault <= 1'b0;
    end else begin
      uninit_fault <= wreg_ptr_use && !wreg_clear &&
        (32'(wreg_ptr_idx) != SP_IDX) && !init_q[wreg_ptr_idx];
    end
  end

endmodule : rcr_wreg_track

/* File: logic/rcr_top.sv */
`timescale 1ns/100ps
module rcr_top #(
  parameter int PC_W = rcr_pkg::RCR_PC_W,
  parameter int NUM_WREG = rcr_pkg::RCR_WREG_NUM
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic trap_conflict,
  input wire logic illegal_opcode,
  input wire logic config_mismatch,
  input wire logic external_reset_pin,
  input wire logic soft_reset_instr,
  input wire logic watchdog_timeout,
  input wire logic power_save_instr,
  input wire logic power_save_idle,
  input wire logic watchdog_clear_instr,
  input wire logic brownout_reset,
  input wire logic wreg_wr,
  input wire logic [$clog2(NUM_WREG)-1:0] wreg_wr_idx,
  input wire logic wreg_ptr_use,
  input wire logic [$clog2(NUM_WREG)-1:0] wreg_ptr_idx,
  input wire logic pc_reload,
  input wire rcr_pkg::rcr_flow_t pc_reload_kind,
  input wire logic [PC_W-1:0] pc_target,
  output logic device_reset,
  output logic security_reset,
  output logic wreg_clear,
  output logic irq
);

  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  if (PC_W < 1 || PC_W > 32) begin : g_chk
    $error("rcr_top: program counter width must be 1 to 32");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [15:0] cause_q;
  logic [15:0] irq_sts_q;
  logic [15:0] irq_en_q;
  logic [PC_W-1:0] seg_lo_q;
  logic [PC_W-1:0] seg_hi_q;
  logic [31:0] rdata_q;
  logic sec_fault_q;
  logic uninit_fault;
  logic [15:0] hw_set;
  logic [15:0] hw_clr;
  logic wr_acc;
  logic wr_cause;
  logic ill_src;
  logic in_seg;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  function automatic logic map_ok(input logic [7:0] a);
    map_ok = (a == rcr_pkg::RCR_OFF_CAUSE) ||
      (a == rcr_pkg::RCR_OFF_IRQ_STS) ||
      (a == rcr_pkg::RCR_OFF_IRQ_CLR) ||
      (a == rcr_pkg::RCR_OFF_IRQ_EN) ||
      (a == rcr_pkg::RCR_OFF_SEG_LO) ||
      (a == rcr_pkg::RCR_OFF_SEG_HI);
  endfunction : map_ok

  // never stalls, so every access phase completes at its first edge
  assign pready = 1'b1;
  assign pslverr = psel && penable && !map_ok(paddr);
  assign wr_acc = psel && penable && pwrite && map_ok(paddr);
  assign wr_cause = wr_acc && (paddr == rcr_pkg::RCR_OFF_CAUSE);
  assign prdata = rdata_q;

  // read data captured in the setup cycle so it leaves a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= '0;
    end else if (psel && !penable && !pwrite) begin
      unique case (paddr)
        rcr_pkg::RCR_OFF_CAUSE: rdata_q <= {16'h0000, cause_q};
        rcr_pkg::RCR_OFF_IRQ_STS: rdata_q <= {16'h0000, irq_sts_q};
        rcr_pkg::RCR_OFF_IRQ_EN: rdata_q <= {16'h0000, irq_en_q};
        rcr_pkg::RCR_OFF_SEG_LO: rdata_q <= 32'(seg_lo_q);
        rcr_pkg::RCR_OFF_SEG_HI: rdata_q <= 32'(seg_hi_q);
        default: rdata_q <= '0; // clear register and holes read zero
      endcase
    end
  end

  // ----------------------------------------------------------------
  // protected segment and security check
  // ----------------------------------------------------------------
  // bounds reset to an empty window so nothing traps before setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seg_lo_q <= '1;
      seg_hi_q <= '0;
    end else if (wr_acc && paddr == rcr_pkg::RCR_OFF_SEG_LO) begin
      seg_lo_q <= pwdata[PC_W-1:0];
    end else if (wr_acc && paddr == rcr_pkg::RCR_OFF_SEG_HI) begin
      seg_hi_q <= pwdata[PC_W-1:0];
    end
  end

  assign in_seg = (pc_target >= seg_lo_q) && (pc_target <= seg_hi_q);

  // both flow kinds are checked against the same window
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sec_fault_q <= 1'b0;
    end else begin
      sec_fault_q <= pc_reload && in_seg &&
        (rcr_pkg::is_pfc(pc_reload_kind) ||
        rcr_pkg::is_vfc(pc_reload_kind));
    end
  end
  assign security_reset = sec_fault_q;

  // ----------------------------------------------------------------
  // working register tracking
  // ----------------------------------------------------------------
  rcr_wreg_track #(
    .NUM_WREG(NUM_WREG),
    .SP_IDX(rcr_pkg::RCR_SP_IDX)
  ) rcr_wreg_track_i (
    .pclk(pclk),
    .presetn(presetn),
    .wreg_clear(wreg_clear),
    .wreg_wr(wreg_wr),
    .wreg_wr_idx(wreg_wr_idx),
    .wreg_ptr_use(wreg_ptr_use),
    .wreg_ptr_idx(wreg_ptr_idx),
    .uninit_fault(uninit_fault)
  );

  assign ill_src = illegal_opcode || uninit_fault || sec_fault_q;

  // one system reset pulse for every cause but power-on, sleep and idle; it also wipes the w file
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      device_reset <= 1'b0;
    end else begin
      device_reset <= ill_src || trap_conflict ||
        config_mismatch || external_reset_pin ||
        soft_reset_instr || watchdog_timeout || brownout_reset;
    end
  end
  assign wreg_clear = device_reset;

  // ----------------------------------------------------------------
  // hardware set and clear terms
  // ----------------------------------------------------------------
  always_comb begin
    hw_set = '0;
    hw_set[rcr_pkg::RCR_B_TRAP] = trap_conflict;
    hw_set[rcr_pkg::RCR_B_ILL] = ill_src;
    hw_set[rcr_pkg::RCR_B_CM] = config_mismatch;
    hw_set[rcr_pkg::RCR_B_PIN] = external_reset_pin;
    hw_set[rcr_pkg::RCR_B_SWR] = soft_reset_instr;
    hw_set[rcr_pkg::RCR_B_WDT] = watchdog_timeout;
    hw_set[rcr_pkg::RCR_B_SLEEP] = power_save_instr && !power_save_idle;
    hw_set[rcr_pkg::RCR_B_IDLE] = power_save_instr && power_save_idle;
    hw_set[rcr_pkg::RCR_B_BOR] = brownout_reset;
    hw_clr = '0;
    if (brownout_reset) begin
      hw_clr = ~rcr_pkg::RCR_BOR_KEEP;
    end
    if (power_save_instr || watchdog_clear_instr) begin
      hw_clr[rcr_pkg::RCR_B_WDT] = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // reset cause flags
  // ----------------------------------------------------------------
  // presetn is the power-on reset; software write, then clear, then
  // set, so an event in the clearing cycle is never lost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cause_q <= rcr_pkg::RCR_CAUSE_RST;
    end else begin
      cause_q <= (((wr_cause ? pwdata[15:0] : cause_q) & ~hw_clr)
        | hw_set) & rcr_pkg::RCR_IMPL_MASK;
    end
  end

  // ----------------------------------------------------------------
  // interrupt
  // ----------------------------------------------------------------
  // sticky copy of each set event; write one to clear, set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_sts_q <= '0;
    end else if (wr_acc && paddr == rcr_pkg::RCR_OFF_IRQ_CLR) begin
      irq_sts_q <= (irq_sts_q & ~pwdata[15:0]) | hw_set;
    end else begin
      irq_sts_q <= irq_sts_q | hw_set;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_en_q <= '0;
    end else if (wr_acc && paddr == rcr_pkg::RCR_OFF_IRQ_EN) begin
      irq_en_q <= pwdata[15:0] & rcr_pkg::RCR_IMPL_MASK;
    end
  end

  assign irq = |(irq_sts_q & irq_en_q);

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence s_fresh_ptr;
    wreg_clear ##1 (wreg_ptr_use && !wreg_wr && !wreg_clear &&
      32'(wreg_ptr_idx) != rcr_pkg::RCR_SP_IDX);
  endsequence

  sequence s_sec_hit;
    pc_reload && in_seg && !brownout_reset && !wr_cause;
  endsequence

  property p_uninit_reset;
    @(posedge pclk) disable iff (!presetn)
    s_fresh_ptr |-> ##2 device_reset;
  endproperty
  a_uninit_reset: assert property (p_uninit_reset)
    else $error("unwritten register pointer did not reset");

  property p_security;
    @(posedge pclk) disable iff (!presetn)
    s_sec_hit |=> security_reset ##1 (device_reset &&
      cause_q[rcr_pkg::RCR_B_ILL]);
  endproperty
  a_security: assert property (p_security)
    else $error("protected target did not raise security reset");

  property p_trap_set;
    @(posedge pclk) disable iff (!presetn)
    trap_conflict |=> cause_q[rcr_pkg::RCR_B_TRAP] && device_reset;
  endproperty
  a_trap_set: assert property (p_trap_set)
    else $error("trap conflict flag not set");

  property p_illop;
    @(posedge pclk) disable iff (!presetn)
    illegal_opcode |=> cause_q[rcr_pkg::RCR_B_ILL] && device_reset;
  endproperty
  a_illop: assert property (p_illop)
    else $error("illegal opcode did not reset");

  property p_pin_keep;
    @(posedge pclk) disable iff (!presetn)
    brownout_reset && !wr_cause |=>
      cause_q[rcr_pkg::RCR_B_PIN] == $past(cause_q[rcr_pkg::RCR_B_PIN]) ||
      cause_q[rcr_pkg::RCR_B_PIN];
  endproperty
  a_pin_keep: assert property (p_pin_keep)
    else $error("pin reset flag lost on brown-out");

  property p_wdt_clr;
    @(posedge pclk) disable iff (!presetn)
    (power_save_instr || watchdog_clear_instr) && !watchdog_timeout
      |=> !cause_q[rcr_pkg::RCR_B_WDT];
  endproperty
  a_wdt_clr: assert property (p_wdt_clr)
    else $error("watchdog flag not cleared");

  property p_sleep;
    @(posedge pclk) disable iff (!presetn)
    power_save_instr && !power_save_idle && !wr_cause && !brownout_reset
      |=> cause_q[rcr_pkg::RCR_B_SLEEP] &&
      cause_q[rcr_pkg::RCR_B_IDLE] == $past(cause_q[rcr_pkg::RCR_B_IDLE]);
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("sleep flag not set");

  property p_bor_bit;
    @(posedge pclk) disable iff (!presetn)
    brownout_reset && !trap_conflict |=> cause_q[rcr_pkg::RCR_B_BOR] &&
      !cause_q[rcr_pkg::RCR_B_TRAP];
  endproperty
  a_bor_bit: assert property (p_bor_bit)
    else $error("brown-out flags wrong");

  property p_sw_write;
    @(posedge pclk) disable iff (!presetn)
    wr_cause && hw_set == 16'h0000 && hw_clr == 16'h0000 |=>
      cause_q == ($past(pwdata[15:0]) & rcr_pkg::RCR_IMPL_MASK);
  endproperty
  a_sw_write: assert property (p_sw_write)
    else $error("software write to flags not applied");

endmodule : rcr_top

/* File: sim/rcr_top_tb.sv */
`timescale 1ns/100ps
module rcr_top_tb;
  // ----------------------------------------------------------------
  // bench signals
  // ----------------------------------------------------------------
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [8:0] ev = 9'h000; // trap ill cm pin swr wdt psave wclr bor
  logic psv_idle = 1'b0;
  logic wreg_wr = 1'b0;
  logic [3:0] wreg_wr_idx = 4'h0;
  logic wreg_ptr_use = 1'b0;
  logic [3:0] wreg_ptr_idx = 4'h0;
  logic pc_reload = 1'b0;
  rcr_pkg::rcr_flow_t pc_reload_kind = rcr_pkg::RCR_K_CALL;
  logic [23:0] pc_target = 24'h00_0000;
  logic device_reset;
  logic security_reset;
  logic wreg_clear;
  logic irq;
  logic [31:0] rd;
  logic err;
  int error_cnt = 0;
  int checks_done = 0;
  int rst_cnt = 0;
  int sec_cnt = 0;
  int clr_cnt = 0;
  int r;
  int bitpos[8] = '{15, 14, 9, 7, 6, 4, 3, 2};
  int evi[8] = '{0, 1, 2, 3, 4, 5, 6, 6};

  // 250 MHz clock
  always #2 pclk = ~pclk;

  rcr_top rcr_top_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .trap_conflict(ev[0]),
    .illegal_opcode(ev[1]), .config_mismatch(ev[2]),
    .external_reset_pin(ev[3]), .soft_reset_instr(ev[4]),
    .watchdog_timeout(ev[5]), .power_save_instr(ev[6]),
    .power_save_idle(psv_idle), .watchdog_clear_instr(ev[7]),
    .brownout_reset(ev[8]), .wreg_wr(wreg_wr), .wreg_wr_idx(wreg_wr_idx),
    .wreg_ptr_use(wreg_ptr_use), .wreg_ptr_idx(wreg_ptr_idx),
    .pc_reload(pc_reload), .pc_reload_kind(pc_reload_kind),
    .pc_target(pc_target), .device_reset(device_reset),
    .security_reset(security_reset), .wreg_clear(wreg_clear), .irq(irq)
  );

  // count reset pulses; pulses are one cycle so edge sampling is exact
  always @(posedge pclk) begin
    if (device_reset === 1'b1) rst_cnt <= rst_cnt + 1;
    if (security_reset === 1'b1) sec_cnt <= sec_cnt + 1;
    if (wreg_clear === 1'b1) clr_cnt <= clr_cnt + 1;
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic close_out;
    $display("errors %0d, checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : chk

  task automatic chk1(input logic exp, input logic got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : chk1

  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      error_cnt++;
      close_out();
    end else begin
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask : apb

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(exp, rd);
  endtask : rchk

  // event pulse, then room for the fault pipeline to drain
  task automatic ev_pulse(input int i, input logic idle);
    @(posedge pclk);
    ev[i] <= 1'b1;
    psv_idle <= idle;
    @(posedge pclk);
    ev <= 9'h000;
    repeat (4) @(posedge pclk);
  endtask : ev_pulse

  task automatic wr_reg(input logic [3:0] idx, input logic ptr);
    @(posedge pclk);
    if (ptr) begin
      wreg_ptr_use <= 1'b1;
      wreg_ptr_idx <= idx;
    end else begin
      wreg_wr <= 1'b1;
      wreg_wr_idx <= idx;
    end
    @(posedge pclk);
    wreg_ptr_use <= 1'b0;
    wreg_wr <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask : wr_reg

  task automatic rld(input int k, input logic [23:0] t);
    @(posedge pclk);
    pc_reload <= 1'b1;
    pc_reload_kind <= rcr_pkg::rcr_flow_t'(k);
    pc_target <= t;
    @(posedge pclk);
    pc_reload <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask : rld

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rchk(rcr_pkg::RCR_OFF_CAUSE, 32'h0000_0003);
    rchk(rcr_pkg::RCR_OFF_IRQ_EN, 32'h0000_0000);
    apb(1'b0, 8'h20, 32'h0000_0000);
    chk1(1'b1, err);
    chk(32'h0000_0000, rd);
    apb(1'b1, rcr_pkg::RCR_OFF_CAUSE, 32'hFFFF_FFFF);
    rchk(rcr_pkg::RCR_OFF_CAUSE, 32'h0000_C2DF);
    apb(1'b1, rcr_pkg::RCR_OFF_CAUSE, 32'h0000_0000);
    rchk(rcr_pkg::RCR_OFF_CAUSE, 32'h0000_0000);
    // pointer use of registers, written and not
    wr_reg(4'h3, 1'b1);
    chk(32'd1, rst_cnt);
    rchk(rcr_pkg::RCR_OFF_CAUSE, 32'h0000_4000);
    wr_reg(4'h5, 1'b0);
    wr_reg(4'h5, 1'b1);
    wr_reg(4'hF, 1'b1);
    chk(32'd1, rst_cnt);
    ev_pulse(0, 1'b0);
    wr_reg(4'h5, 1'b1);
    chk(32'd3, rst_cnt);
    chk(rst_cnt, clr_cnt);
    // pointer use in the very first cycle after the register file clear
    r = rst_cnt;
    wr_reg(4'h5, 1'b0);
    @(posedge pclk);
    ev[0] <= 1'b1;
    @(posedge pclk);
    ev <= 9'h000;
    wr_reg(4'h5, 1'b1);
    chk(r + 2, rst_cnt);
    // empty window after reset: no violation possible
    rld(0, 24'h00_1800);
    chk(32'd0, sec_cnt);
    apb(1'b1, rcr_pkg::RCR_OFF_SEG_LO, 32'h0000_1000);
    apb(1'b1, rcr_pkg::RCR_OFF_SEG_HI, 32'h0000_1FFF);
    for (int k = 0; k < 8; k++) begin
      rld(k, (k % 2) ? 24'h00_1FFF : 24'h00_1000);
      rld(k, (k % 2) ? 24'h00_2000 : 24'h00_0FFF);
      chk(k + 1, sec_cnt);
    end
    apb(1'b1, rcr_pkg::RCR_OFF_CAUSE, 32'h0000_0000);
    rld(7, 24'h00_1800);
    rchk(rcr_pkg::RCR_OFF_CAUSE, 32'h0000_4000);
    // each cause flag but power-on and brown-out from its own event
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, rcr_pkg::RCR_OFF_CAUSE, 32'h0000_0000);
      r = rst_cnt;
      ev_pulse(evi[i], i == 7);
      rchk(rcr_pkg::RCR_OFF_CAUSE,
        32'h1 << bitpos[i]);
      if (i == 1) chk(r + 1, rst_cnt);
    end
    // watchdog flag cleared by clear and power-save instructions
    apb(1'b1, rcr_pkg::RCR_OFF_CAUSE, 32'h0000_0010);
    ev_pulse(7, 1'b0);
    rchk(rcr_pkg::RCR_OFF_CAUSE, 32'h0000_0000);
    apb(1'b1, rcr_pkg::RCR_OFF_CAUSE, 32'h0000_0010);
    ev_pulse(6, 1'b1);
    rchk(rcr_pkg::RCR_OFF_CAUSE, 32'h0000_0004);
    // brown-out keeps pin and power-on flags only
    apb(1'b1, rcr_pkg::RCR_OFF_CAUSE, 32'h0000_C2DC);
    ev_pulse(8, 1'b0);
    rchk(rcr_pkg::RCR_OFF_CAUSE,
      32'h0000_0082);
    // interrupt: raise, mask, clear
    apb(1'b1, rcr_pkg::RCR_OFF_IRQ_CLR, 32'h0000_FFFF);
    rchk(rcr_pkg::RCR_OFF_IRQ_STS, 32'h0000_0000);
    apb(1'b1, rcr_pkg::RCR_OFF_IRQ_EN, 32'h0000_0080);
    rchk(rcr_pkg::RCR_OFF_IRQ_EN, 32'h0000_0080);
    ev_pulse(4, 1'b0);
    chk1(1'b0, irq);
    rchk(rcr_pkg::RCR_OFF_IRQ_STS, 32'h0000_0040);
    ev_pulse(3, 1'b0);
    chk1(1'b1, irq);
    apb(1'b1, rcr_pkg::RCR_OFF_IRQ_STS, 32'h0000_0000);
    @(posedge pclk);
    chk1(1'b1, irq);
    apb(1'b1, rcr_pkg::RCR_OFF_IRQ_CLR, 32'h0000_0080);
    @(posedge pclk);
    chk1(1'b0, irq);
    // power-on in mid-run clears the pin flag too
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rchk(rcr_pkg::RCR_OFF_CAUSE, 32'h0000_0003);
    close_out();
  end
endmodule : rcr_top_tb
